// *** read_response_error_reporter_tb.sv ***
// Self-checking bench for the read response and error report framer
`timescale 1ns/100ps
module read_response_error_reporter_tb;
	import rrer_pkg::*;
	logic mclk_i = 1'b0;
	logic rstn_i = 1'b0;
	logic link_clk_i, turnaround_i, tx_valid_o, tx_end_o, ack_trig_o, drop_o;
	logic rd_take_o, req_done_o, avs_waitrequest_o, irq_o;
	logic [7:0] tx_data_o, rd_data_i;
	logic [7:0] pidx = 8'h00;
	logic [15:0] err_i = 16'h0000;
	logic [15:0] req_len_i = 16'h0000;
	logic [15:0] req_data_i = 16'h0000;
	logic rx_end_i = 1'b0;
	logic req_valid_i = 1'b0;
	logic req_panel_i = 1'b0;
	logic req_long_i = 1'b0;
	logic [1:0] req_tag_i = 2'h0;
	logic [4:0] avs_address_i = 5'h00;
	logic avs_read_i = 1'b0;
	logic avs_write_i = 1'b0;
	logic [3:0] avs_byteenable_i = 4'hF;
	logic [31:0] avs_writedata_i = 32'h0000_0000;
	logic [31:0] avs_readdata_o, rq;
	logic [7:0] exq[$];
	int num_errors = 0;
	int compares = 0;
	int acks = 0;
	int dones = 0;
	int d0 = 0;
	int cyc = 0;
	assign rd_data_i = 8'hA5 ^ pidx;
	always #12.5 mclk_i = ~mclk_i;
	rrer_framer u_rrer_framer (.mclk_i, .rstn_i, .link_clk_i, .turnaround_i, .tx_data_o,
		.tx_valid_o, .tx_end_o, .ack_trig_o, .err_i, .rx_end_i, .drop_o, .req_valid_i,
		.req_panel_i, .req_long_i, .req_len_i, .req_data_i, .req_tag_i, .rd_data_i, .rd_take_o,
		.req_done_o, .avs_address_i, .avs_read_i, .avs_write_i, .avs_writedata_i,
		.avs_byteenable_i, .avs_readdata_o, .avs_waitrequest_o, .irq_o);
	rrer_host u_rrer_host (.mclk_i, .tx_data_i(tx_data_o), .tx_valid_i(tx_valid_o),
		.tx_end_i(tx_end_o), .link_clk_o(link_clk_i), .turnaround_o(turnaround_i));
	always @(posedge mclk_i) begin
		cyc++;
		if (ack_trig_o === 1'b1)
			acks++;
		if (req_done_o === 1'b1)
			dones++;
		if (rd_take_o === 1'b1)
			pidx <= pidx + 8'h01;
		if (cyc == 20000) begin
			num_errors++;
			$display("CHECK FAILED t=%0t timeout", $time);
			end_of_test();
		end
	end
	////////////////////////////////////////////////////////////////
	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		compares++;
		if (g !== e) begin
			num_errors++;
			$display("CHECK FAILED t=%0t got %h exp %h", $time, g, e);
		end
	endtask : chk
	function automatic logic [7:0] ecc(input logic [23:0] h);
		return {2'b00, ^(h & ECC_M5), ^(h & ECC_M4), ^(h & ECC_M3), ^(h & ECC_M2),
			^(h & ECC_M1), ^(h & ECC_M0)};
	endfunction : ecc
	function automatic logic [15:0] crc(input logic [7:0] d[$]);
		logic [15:0] c;
		c = CRC_INIT;
		foreach (d[i])
			for (int b = 0; b < 8; b++)
				c = (c[0] ^ d[i][b]) ? ((c >> 1) ^ CRC_POLY) : (c >> 1);
		return c;
	endfunction : crc
	task automatic hdr(input logic [7:0] b0, input logic [7:0] b1, input logic [7:0] b2);
		exq = {exq, b0, b1, b2, ecc({b2, b1, b0})};
	endtask : hdr
	task automatic pkt;
		int a0;
		a0 = acks;
		u_rrer_host.turn(exq.size());
		chk(32'(acks - a0), 32'(exq.size() == 0));
		chk(32'(u_rrer_host.fin), 32'(exq.size() != 0));
		chk(32'(u_rrer_host.got.size()), 32'(exq.size()));
		foreach (exq[i])
			if (i < u_rrer_host.got.size())
				chk(u_rrer_host.got[i], exq[i]);
		exq.delete();
	endtask : pkt
	task automatic bus(input logic [4:0] a, input logic wr, input logic [31:0] d);
		avs_address_i <= a;
		avs_write_i <= wr;
		avs_read_i <= ~wr;
		avs_writedata_i <= d;
		do
			@(posedge mclk_i);
		while (avs_waitrequest_o !== 1'b0);
		rq = avs_readdata_o;
		avs_read_i <= 1'b0;
		avs_write_i <= 1'b0;
		@(posedge mclk_i);
	endtask : bus
	task automatic req(input logic p, input logic l, input logic [15:0] n, input logic [15:0] d);
		req_valid_i <= 1'b1;
		req_panel_i <= p;
		req_long_i <= l;
		req_len_i <= n;
		req_data_i <= d;
		req_tag_i <= 2'b10;
		pidx <= 8'h00;
		d0 = dones;
	endtask : req
	task automatic done_req;
		req_valid_i <= 1'b0;
		chk(dones - d0, 1);
		@(posedge mclk_i);
	endtask : done_req
	task automatic pulse(input logic [15:0] e);
		err_i <= e;
		rx_end_i <= ~|e;
		@(posedge mclk_i);
		err_i <= 16'h0000;
		rx_end_i <= 1'b0;
		@(posedge mclk_i);
	endtask : pulse
	////////////////////////////////////////////////////////////////
	task automatic t_short;
		logic [5:0] ty;
		for (int i = 0; i < 4; i++) begin
			if (i == 3)
				pulse(16'h0100);
			ty = i[1] ? (i[0] ? TYPE_PSHORT2 : TYPE_PSHORT1) : (i[0] ? TYPE_GSHORT2 : TYPE_GSHORT1);
			req(i[1], 1'b0, {14'h0000, i[0], ~i[0]}, 16'hBE00 + 16'(i));
			hdr({2'b10, ty}, 8'(i), i[0] ? 8'hBE : FILL_BYTE);
			if (i == 3)
				hdr({REPORT_TAG, TYPE_ACK_ERR}, 8'h00, 8'h01);
			pkt();
			done_req();
		end
	endtask : t_short
	task automatic t_long;
		logic [7:0] p[$];
		logic [15:0] c;
		p = {8'hA5, 8'hA4, 8'hA7};
		for (int i = 0; i < 2; i++) begin
			bus(REG_CTRL, 1'b1, {31'h0000_0000, ~i[0]});
			req(i[0], 1'b1, 16'h0003, 16'h0000);
			hdr({2'b10, i[0] ? TYPE_PLONG : TYPE_GLONG}, 8'h03, 8'h00);
			c = i[0] ? CSUM_OFF : crc(p);
			exq = {exq, p, c[7:0], c[15:8]};
			pkt();
			done_req();
		end
		bus(REG_CTRL, 1'b1, 32'h0000_0001);
	endtask : t_long
	task automatic t_withheld;
		int b[3] = '{ERR_START, ERR_START_SYNC, ERR_ECC2};
		logic [15:0] f;
		for (int i = 0; i < 3; i++) begin
			f = 16'h0001 << b[i];
			pulse(f);
			if (i == 2) begin
				chk(drop_o, 1'b1);
				pulse(16'h0000);
				chk(drop_o, 1'b0);
			end
			req(1'b0, 1'b0, 16'h0001, 16'h0055);
			hdr({REPORT_TAG, TYPE_ACK_ERR}, f[7:0], f[15:8]);
			pkt();
			done_req();
		end
	endtask : t_withheld
	task automatic t_accum;
		int a0;
		pulse(16'h0800);
		pulse(16'h0000);
		pulse(16'h8000);
		bus(REG_FLAGS, 1'b0, 32'h0000_0000);
		chk(rq, 32'h0000_8800);
		hdr({REPORT_TAG, TYPE_ACK_ERR}, 8'h00, 8'h88);
		pkt();
		bus(REG_FLAGS, 1'b0, 32'h0000_0000);
		chk(rq, 32'h0000_0000);
		a0 = acks;
		pkt();
		chk(acks - a0, 1);
	endtask : t_accum
	task automatic t_irq;
		bus(REG_IRQ_ENA, 1'b0, 32'h0000_0000);
		chk(rq, 32'h0000_0000);
		chk(irq_o, 1'b0);
		bus(REG_IRQ_STS, 1'b0, 32'h0000_0000);
		chk(rq, 32'h0000_0007);
		bus(REG_IRQ_ENA, 1'b1, 32'h0000_0004);
		chk(irq_o, 1'b1);
		// Write with low byte lane off must be ignored
		avs_byteenable_i <= 4'hE;
		bus(REG_IRQ_ENA, 1'b1, 32'h0000_0000);
		avs_byteenable_i <= 4'hF;
		chk(irq_o, 1'b1);
		bus(REG_IRQ_CLR, 1'b1, 32'h0000_0004);
		chk(irq_o, 1'b0);
		bus(5'h1C, 1'b0, 32'h0000_0000);
		chk(rq, 32'h0000_0000);
	endtask : t_irq
	task automatic end_of_test;
		if (num_errors == 0 && compares > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask : end_of_test
	initial begin
		repeat (10) @(posedge mclk_i);
		rstn_i <= 1'b1;
		repeat (3) @(posedge mclk_i);
		bus(REG_CTRL, 1'b0, 32'h0000_0000);
		chk(rq, 32'h0000_0001);
		t_short();
		t_long();
		t_withheld();
		t_accum();
		t_irq();
		end_of_test();
	end
endmodule : read_response_error_reporter_tb

// *** rrer_framer.sv ***
// Reverse-direction packet framer: read responses and error reports
`timescale 1ns/100ps
module rrer_framer
	import rrer_pkg::*;
(
	// Clock and reset
	input wire logic mclk_i,
	input wire logic rstn_i,
	// Link pins
	input wire logic link_clk_i,
	input wire logic turnaround_i,
	output logic [7:0] tx_data_o,
	output logic tx_valid_o,
	output logic tx_end_o,
	output logic ack_trig_o,
	// Receiver side error events and transmission end
	input wire logic [15:0] err_i,
	input wire logic rx_end_i,
	output logic drop_o,
	// Pending read request and its data
	input wire logic req_valid_i,
	input wire logic req_panel_i,
	input wire logic req_long_i,
	input wire logic [15:0] req_len_i,
	input wire logic [15:0] req_data_i,
	input wire logic [1:0] req_tag_i,
	input wire logic [7:0] rd_data_i,
	output logic rd_take_o,
	output logic req_done_o,
	// Avalon-MM slave
	input wire logic [4:0] avs_address_i,
	input wire logic avs_read_i,
	input wire logic avs_write_i,
	input wire logic [31:0] avs_writedata_i,
	input wire logic [3:0] avs_byteenable_i,
	output logic [31:0] avs_readdata_o,
	output logic avs_waitrequest_o,
	output logic irq_o
);
	import rrer_pkg::*;

	typedef enum logic [1:0] {ST_IDLE, ST_HDR, ST_DATA, ST_SUM} rrer_st_t;

	function automatic logic [7:0] hdr_ecc(input logic [23:0] h);
		hdr_ecc = {2'b00, ^(h & ECC_M5), ^(h & ECC_M4), ^(h & ECC_M3),
			^(h & ECC_M2), ^(h & ECC_M1), ^(h & ECC_M0)};
	endfunction : hdr_ecc

	function automatic logic [31:0] mk_hdr(input logic [1:0] tag, input logic [5:0] ptype,
		input logic [7:0] b1, input logic [7:0] b2);
		logic [23:0] h;
		h = {b2, b1, tag, ptype};
		mk_hdr = {hdr_ecc(h), h};
	endfunction : mk_hdr

	function automatic logic [15:0] crc_upd(input logic [15:0] c, input logic [7:0] b);
		logic [15:0] r;
		r = c;
		for (int i = 0; i < 8; i++) begin
			r = (r[0] ^ b[i]) ? ((r >> 1) ^ CRC_POLY) : (r >> 1);
		end
		crc_upd = r;
	endfunction : crc_upd

	////////////////////////////////////////////////////////////////
	// Pin synchronisers and edge finding
	logic [2:0] lclk_s;
	logic [2:0] turn_s;
	logic tick;
	logic turn_rise;

	always_ff @(posedge mclk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			lclk_s <= 3'b000;
			turn_s <= 3'b000;
		end else begin
			lclk_s <= {lclk_s[1:0], link_clk_i};
			turn_s <= {turn_s[1:0], turnaround_i};
		end
	end

	assign tick = lclk_s[1] & ~lclk_s[2];
	assign turn_rise = turn_s[1] & ~turn_s[2];

	////////////////////////////////////////////////////////////////
	// Framer state machine
	rrer_st_t st;
	logic [31:0] hdr;
	logic [15:0] idx;
	logic [15:0] len;
	logic [15:0] crc;
	logic [15:0] flags;
	logic [15:0] snap;
	logic cur_rep;
	logic need_rep;
	logic is_long;
	logic csum_en;
	logic clr_q;
	logic bad_req;
	logic [5:0] rd_type;
	logic [31:0] rd_hdr;
	logic [31:0] rep_hdr;
	logic [15:0] csum;
	logic pkt_end;
	logic [IRQ_W-1:0] evt;

	// Request may be corrupt: its header may name the wrong thing
	assign bad_req = flags[ERR_START] | flags[ERR_START_SYNC] | flags[ERR_ECC2];

	always_comb begin
		if (req_long_i) begin
			rd_type = req_panel_i ? TYPE_PLONG : TYPE_GLONG;
		end else if (req_panel_i) begin
			rd_type = req_len_i[1] ? TYPE_PSHORT2 : TYPE_PSHORT1;
		end else begin
			rd_type = req_len_i[1] ? TYPE_GSHORT2 : TYPE_GSHORT1;
		end
	end

	assign rd_hdr = req_long_i ? mk_hdr(req_tag_i, rd_type, req_len_i[7:0], req_len_i[15:8])
		: mk_hdr(req_tag_i, rd_type, req_data_i[7:0],
		req_len_i[1] ? req_data_i[15:8] : FILL_BYTE);
	assign rep_hdr = mk_hdr(REPORT_TAG, TYPE_ACK_ERR, flags[7:0], flags[15:8]);
	assign csum = csum_en ? crc : CSUM_OFF;
	assign pkt_end = tick & (((st == ST_HDR) & (idx == 16'd3) & (cur_rep | ~is_long))
		| ((st == ST_SUM) & (idx == 16'd1)));

	always_ff @(posedge mclk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			st <= ST_IDLE;
			hdr <= '0;
			idx <= '0;
			len <= '0;
			crc <= CRC_INIT;
			snap <= '0;
			cur_rep <= 1'b0;
			need_rep <= 1'b0;
			is_long <= 1'b0;
			clr_q <= 1'b0;
			tx_data_o <= '0;
			tx_valid_o <= 1'b0;
			tx_end_o <= 1'b0;
			ack_trig_o <= 1'b0;
			rd_take_o <= 1'b0;
			req_done_o <= 1'b0;
			evt <= '0;
		end else begin
			tx_valid_o <= 1'b0;
			tx_end_o <= 1'b0;
			ack_trig_o <= 1'b0;
			rd_take_o <= 1'b0;
			req_done_o <= 1'b0;
			clr_q <= 1'b0;
			evt <= '0;
			case (st)
				ST_IDLE: begin
					idx <= '0;
					crc <= CRC_INIT;
					if (turn_rise) begin
						if (req_valid_i & ~bad_req) begin
							hdr <= rd_hdr;
							len <= req_len_i;
							is_long <= req_long_i;
							cur_rep <= 1'b0;
							need_rep <= |flags;
							st <= ST_HDR;
						end else if (|flags) begin
							// Withheld request is consumed; report alone
							hdr <= rep_hdr;
							snap <= flags;
							cur_rep <= 1'b1;
							need_rep <= 1'b0;
							req_done_o <= req_valid_i;
							evt[IRQ_WITHHELD] <= req_valid_i;
							st <= ST_HDR;
						end else begin
							ack_trig_o <= 1'b1;
						end
					end
				end
				ST_HDR: begin
					if (tick) begin
						tx_data_o <= hdr[8*idx[1:0] +: 8];
						tx_valid_o <= 1'b1;
						idx <= idx + 16'd1;
						if (idx == 16'd3 && is_long && !cur_rep) begin
							idx <= '0;
							st <= (len == 16'd0) ? ST_SUM : ST_DATA;
						end
					end
				end
				ST_DATA: begin
					if (tick) begin
						tx_data_o <= rd_data_i;
						tx_valid_o <= 1'b1;
						rd_take_o <= 1'b1;
						crc <= crc_upd(crc, rd_data_i);
						idx <= idx + 16'd1;
						if (idx == len - 16'd1) begin
							idx <= '0;
							st <= ST_SUM;
						end
					end
				end
				ST_SUM: begin
					if (tick) begin
						tx_data_o <= idx[0] ? csum[15:8] : csum[7:0];
						tx_valid_o <= 1'b1;
						idx <= idx + 16'd1;
					end
				end
				default: begin
					st <= ST_IDLE;
				end
			endcase
			if (pkt_end) begin
				idx <= '0;
				if (cur_rep) begin
					clr_q <= 1'b1;
					tx_end_o <= 1'b1;
					evt[IRQ_REPORT] <= 1'b1;
					st <= ST_IDLE;
				end else begin
					req_done_o <= 1'b1;
					evt[IRQ_READ] <= 1'b1;
					if (need_rep) begin
						// Report follows in the same reverse transmission
						hdr <= rep_hdr;
						snap <= flags;
						cur_rep <= 1'b1;
						need_rep <= 1'b0;
						st <= ST_HDR;
					end else begin
						tx_end_o <= 1'b1;
						st <= ST_IDLE;
					end
				end
			end
		end
	end

	////////////////////////////////////////////////////////////////
	// Error accumulation; a new event wins over the clear
	always_ff @(posedge mclk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			flags <= '0;
		end else begin
			flags <= (flags & ~(clr_q ? snap : 16'h0000)) | err_i;
		end
	end

	// Packet boundaries are lost, so ignore input until the transmission ends
	always_ff @(posedge mclk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			drop_o <= 1'b0;
		end else if (err_i[ERR_ECC2] | err_i[ERR_TYPE]) begin
			drop_o <= 1'b1;
		end else if (rx_end_i) begin
			drop_o <= 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////
	// Register slave and interrupt
	logic bus_ack;
	logic [IRQ_W-1:0] irq_sts;
	logic [IRQ_W-1:0] irq_ena;
	logic wr_go;

	assign avs_waitrequest_o = (avs_read_i | avs_write_i) & ~bus_ack;
	assign wr_go = avs_write_i & bus_ack & avs_byteenable_i[0];
	assign irq_o = |(irq_sts & irq_ena);

	always_ff @(posedge mclk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			bus_ack <= 1'b0;
			avs_readdata_o <= '0;
		end else begin
			bus_ack <= (avs_read_i | avs_write_i) & ~bus_ack;
			if (avs_read_i && !bus_ack) begin
				case (avs_address_i)
					REG_CTRL: avs_readdata_o <= {31'd0, csum_en};
					REG_FLAGS: avs_readdata_o <= {16'd0, flags};
					REG_IRQ_STS: avs_readdata_o <= {29'd0, irq_sts};
					REG_IRQ_ENA: avs_readdata_o <= {29'd0, irq_ena};
					default: avs_readdata_o <= '0;
				endcase
			end
		end
	end

	always_ff @(posedge mclk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			csum_en <= CTRL_CSUM_RST;
			irq_ena <= IRQ_ENA_RST;
		end else if (wr_go && avs_address_i == REG_CTRL) begin
			csum_en <= avs_writedata_i[0];
		end else if (wr_go && avs_address_i == REG_IRQ_ENA) begin
			irq_ena <= avs_writedata_i[IRQ_W-1:0];
		end
	end

	always_ff @(posedge mclk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			irq_sts <= '0;
		end else if (wr_go && avs_address_i == REG_IRQ_CLR) begin
			irq_sts <= (irq_sts & ~avs_writedata_i[IRQ_W-1:0]) | evt;
		end else begin
			irq_sts <= irq_sts | evt;
		end
	end

	////////////////////////////////////////////////////////////////
	// Checks
	a_report_type_tag: assert property (@(posedge mclk_i) disable iff (!rstn_i)
		(st == ST_HDR && cur_rep) |-> hdr[7:0] == {REPORT_TAG, TYPE_ACK_ERR})
		else $error("report header type or tag wrong");
	a_short_fill: assert property (@(posedge mclk_i) disable iff (!rstn_i)
		(st == ST_HDR && !cur_rep && (hdr[5:0] == TYPE_GSHORT1 || hdr[5:0] == TYPE_PSHORT1))
		|-> hdr[23:16] == FILL_BYTE)
		else $error("one-byte response high byte not zero");
	a_withhold_read: assert property (@(posedge mclk_i) disable iff (!rstn_i)
		(turn_rise && st == ST_IDLE && bad_req) |=> (st == ST_IDLE || cur_rep))
		else $error("read data sent for corrupt request");
	a_flags_kept: assert property (@(posedge mclk_i) disable iff (!rstn_i)
		!clr_q |=> (flags & $past(flags)) == $past(flags))
		else $error("error flag lost without report");
	a_clear_on_send: assert property (@(posedge mclk_i) disable iff (!rstn_i)
		clr_q |-> (tx_end_o && $past(cur_rep) && $past(st) == ST_HDR))
		else $error("flags cleared outside report end");
	a_header_ecc: assert property (@(posedge mclk_i) disable iff (!rstn_i)
		st == ST_HDR |-> hdr[31:24] == hdr_ecc(hdr[23:0]))
		else $error("header ECC mismatch");
	a_single_report: assert property (@(posedge mclk_i) disable iff (!rstn_i)
		(st != ST_IDLE && cur_rep) |-> !need_rep)
		else $error("second report queued");
	a_sum_zero: assert property (@(posedge mclk_i) disable iff (!rstn_i)
		(st == ST_SUM && tick && !csum_en) |=> (tx_valid_o && tx_data_o == 8'h00))
		else $error("checksum byte not zero when disabled");
	a_long_type: assert property (@(posedge mclk_i) disable iff (!rstn_i)
		(st == ST_DATA) |-> (hdr[5:0] == TYPE_GLONG || hdr[5:0] == TYPE_PLONG))
		else $error("long payload under short type");
	a_drop_set: assert property (@(posedge mclk_i) disable iff (!rstn_i)
		(err_i[ERR_ECC2] || err_i[ERR_TYPE]) |=> drop_o)
		else $error("transmission not dropped");
	a_report_follows: assert property (@(posedge mclk_i) disable iff (!rstn_i)
		(pkt_end && !cur_rep && need_rep) |=> (st == ST_HDR && cur_rep && !tx_end_o))
		else $error("report not chained after read");
endmodule : rrer_framer

// *** rrer_host.sv ***
// Host-side partner model: link clock, bus turnaround and byte capture
`timescale 1ns/100ps
module rrer_host (
	// Clock
	input wire logic mclk_i,
	// Reverse traffic from the device
	input wire logic [7:0] tx_data_i,
	input wire logic tx_valid_i,
	input wire logic tx_end_i,
	// Link pins driven by the host
	output logic link_clk_o,
	output logic turnaround_o
);
	logic [7:0] got[$];
	logic run = 1'b0;
	logic fin = 1'b0;
	initial begin
		link_clk_o = 1'b0;
		turnaround_o = 1'b0;
		// Odd offset keeps the link clock out of phase with mclk
		#13;
		forever #100 link_clk_o = run & ~link_clk_o;
	end
	always @(posedge mclk_i) begin
		if (tx_valid_i === 1'b1)
			got.push_back(tx_data_i);
		if (tx_end_i === 1'b1)
			fin <= 1'b1;
	end
	////////////////////////////////////////////////////////////////
	// One transmission, then hand the bus over; clock stands between frames
	task automatic turn(input int n);
		got.delete();
		fin = 1'b0;
		@(posedge mclk_i);
		turnaround_o <= 1'b1;
		run <= 1'b1;
		repeat (n * 10 + 40) begin
			@(posedge mclk_i);
			if (fin)
				break;
		end
		run <= 1'b0;
		turnaround_o <= 1'b0;
		repeat (4) @(posedge mclk_i);
	endtask : turn
endmodule : rrer_host

// *** rrer_pkg.sv ***
// Shared constants for the read response and error report framer
package rrer_pkg;
	// Packet type codes sent toward the host
	localparam logic [5:0] TYPE_ACK_ERR = 6'h02;
	localparam logic [5:0] TYPE_GSHORT1 = 6'h11;
	localparam logic [5:0] TYPE_GSHORT2 = 6'h12;
	localparam logic [5:0] TYPE_GLONG = 6'h1A;
	localparam logic [5:0] TYPE_PLONG = 6'h1C;
	localparam logic [5:0] TYPE_PSHORT1 = 6'h21;
	localparam logic [5:0] TYPE_PSHORT2 = 6'h22;
	localparam logic [1:0] REPORT_TAG = 2'b00;
	localparam logic [7:0] FILL_BYTE = 8'h00;
	localparam logic [15:0] CSUM_OFF = 16'h0000;
	localparam logic [15:0] CRC_INIT = 16'hFFFF;
	localparam logic [15:0] CRC_POLY = 16'h8408;
	// Error flag positions
	localparam int ERR_START = 0;
	localparam int ERR_START_SYNC = 1;
	localparam int ERR_ECC1 = 8;
	localparam int ERR_ECC2 = 9;
	localparam int ERR_TYPE = 11;
	localparam int ERR_PROTO = 15;
	// Header code parity masks, one per ECC bit
	localparam logic [23:0] ECC_M0 = 24'hF1_2CB7;
	localparam logic [23:0] ECC_M1 = 24'hF2_555B;
	localparam logic [23:0] ECC_M2 = 24'h74_A96D;
	localparam logic [23:0] ECC_M3 = 24'hB8_E38E;
	localparam logic [23:0] ECC_M4 = 24'hDF_03F0;
	localparam logic [23:0] ECC_M5 = 24'hEF_FC00;
	// Register byte offsets
	localparam logic [4:0] REG_CTRL = 5'h00;
	localparam logic [4:0] REG_FLAGS = 5'h04;
	localparam logic [4:0] REG_IRQ_STS = 5'h08;
	localparam logic [4:0] REG_IRQ_CLR = 5'h0C;
	localparam logic [4:0] REG_IRQ_ENA = 5'h10;
	// Reset values and interrupt bits
	localparam logic CTRL_CSUM_RST = 1'b1;
	localparam logic [2:0] IRQ_ENA_RST = 3'h0;
	localparam int IRQ_REPORT = 0;
	localparam int IRQ_READ = 1;
	localparam int IRQ_WITHHELD = 2;
	localparam int IRQ_W = 3;
endpackage : rrer_pkg
